// ===== inc/scan_map.vh
/*
 * constants of the scan transceiver: test opcodes, scan lengths,
 * boundary cell layout, run-test operations and controller states.
 * assumes inclusion by bare name from the sequencer and transceiver design files.
 */
`ifndef SCAN_MAP_VH
`define SCAN_MAP_VH

// ****************************************************
// scan lengths
// ****************************************************
`define IR_W        8
`define BSR_W       48
`define BCR_W       3
`define ID_W        32

// ****************************************************
// instruction register values (even parity)
// ****************************************************
`define IR_RESET    8'h81
`define IR_CAPTURE  8'h81
`define OP_EXTEST   8'h00
`define OP_IDCODE   8'h81
`define OP_SAMPLE   8'h82
`define OP_INTEST   8'h03
`define OP_HIGHZ    8'h06
`define OP_CLAMP    8'h87
`define OP_RUNT     8'h09
`define OP_SCANCN   8'h0a
`define OP_BYPASS   8'hff

// ****************************************************
// boundary-control operations
// ****************************************************
`define BCR_RESET   3'h2
`define BCR_TOGGLE  3'h0
`define BCR_OUTPUT_RANDOM_PATTERN    3'h1
`define BCR_PSA     3'h2
`define BCR_COUNT   3'h3

// ****************************************************
// boundary cell layout
// ****************************************************
`define BSR_OE_LO   44
`define BSR_LE_LO   40
`define BSR_CK_LO   36
`define BSR_A_LO    18
`define BSR_B_LO    0
`define BSR_OE_SET  4'hf

// ****************************************************
// controller states
// ****************************************************
`define TAP_TLR     4'h0
`define TAP_RTI     4'h1
`define TAP_SDS     4'h2
`define TAP_CDR     4'h3
`define TAP_SHDR    4'h4
`define TAP_E1DR    4'h5
`define TAP_PDR     4'h6
`define TAP_E2DR    4'h7
`define TAP_UDR     4'h8
`define TAP_SIS     4'h9
`define TAP_CIR     4'ha
`define TAP_SHIR    4'hb
`define TAP_E1IR    4'hc
`define TAP_PIR     4'hd
`define TAP_E2IR    4'he
`define TAP_UIR     4'hf

`endif

// ===== src/store_path.v
/*
 * one direction of one transceiver half: latch/flip-flop store.
 * assumes all inputs already synchronised to sys_clk.
 */
module store_path #(
	parameter W = 9
) (
	// clock and reset
	input  wire         sys_clk,
	input  wire         nrst,
	// synchronised pins
	input  wire [W-1:0] d,
	input  wire         latch_en,
	input  wire         store_clk,
	// transparent or stored value
	output wire [W-1:0] q
);

reg         clk_d;
reg [W-1:0] st;

// store on store clock rise while the latch is closed
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		clk_d <= 1'b0;
		st <= {W{1'b0}};
	end else begin
		clk_d <= store_clk;
		if (!latch_en && store_clk && !clk_d)
			st <= d;
	end
end

// open latch passes, else the stored word stands
assign q = latch_en ? d : st;

endmodule

// ===== src/tap_states.v
/*
 * test port state sequencer, sixteen states.
 * assumes tck_rise is a one-cycle strobe from a sampled test clock.
 */
`include "scan_map.vh"

module tap_states (
	// clock and reset
	input  wire       sys_clk,
	input  wire       nrst,
	// sampled test port
	input  wire       tck_rise,
	input  wire       tms,
	// current state
	output reg  [3:0] state
);

// advance once per test clock rise, steered by the select level
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		state <= `TAP_TLR;
	end else if (tck_rise) begin
		case (state)
		`TAP_TLR:  state <= tms ? `TAP_TLR  : `TAP_RTI;
		`TAP_RTI:  state <= tms ? `TAP_SDS  : `TAP_RTI;
		`TAP_SDS:  state <= tms ? `TAP_SIS  : `TAP_CDR;
		`TAP_CDR:  state <= tms ? `TAP_E1DR : `TAP_SHDR;
		`TAP_SHDR: state <= tms ? `TAP_E1DR : `TAP_SHDR;
		`TAP_E1DR: state <= tms ? `TAP_UDR  : `TAP_PDR;
		`TAP_PDR:  state <= tms ? `TAP_E2DR : `TAP_PDR;
		`TAP_E2DR: state <= tms ? `TAP_UDR  : `TAP_SHDR;
		`TAP_UDR:  state <= tms ? `TAP_SDS  : `TAP_RTI;
		`TAP_SIS:  state <= tms ? `TAP_TLR  : `TAP_CIR;
		`TAP_CIR:  state <= tms ? `TAP_E1IR : `TAP_SHIR;
		`TAP_SHIR: state <= tms ? `TAP_E1IR : `TAP_SHIR;
		`TAP_E1IR: state <= tms ? `TAP_UIR  : `TAP_PIR;
		`TAP_PIR:  state <= tms ? `TAP_E2IR : `TAP_PIR;
		`TAP_E2IR: state <= tms ? `TAP_UIR  : `TAP_SHIR;
		`TAP_UIR:  state <= tms ? `TAP_SDS  : `TAP_RTI;
		default:   state <= `TAP_TLR;
		endcase
	end
end

endmodule

// ===== src/scan_bus_transceiver_18bit.v
/*
 * 18-bit bus transceiver with boundary-scan test port.
 * all pins, the test clock among them, are sampled by sys_clk, which
 * must run well above the test clock and the store clocks.
 * two-way pins are split into input, output and output enable.
 */
`include "scan_map.vh"

module scan_bus_transceiver_18bit #(
	parameter        HALF_W  = 9,
	parameter [31:0] ID_CODE = 32'h0a5a_0001 // arbitrary value
) (
	// clock and reset
	input  wire                  sys_clk,
	input  wire                  nrst,
	// A port
	input  wire [2*HALF_W-1:0]   a_in,
	output reg  [2*HALF_W-1:0]   a_out,
	output reg  [2*HALF_W-1:0]   a_oe,
	// B port
	input  wire [2*HALF_W-1:0]   b_in,
	output reg  [2*HALF_W-1:0]   b_out,
	output reg  [2*HALF_W-1:0]   b_oe,
	// per-half controls, bit 0 is half 1
	input  wire [1:0]            fwd_out_en_n,
	input  wire [1:0]            rev_out_en_n,
	input  wire [1:0]            fwd_latch_en,
	input  wire [1:0]            rev_latch_en,
	input  wire [1:0]            fwd_store_clk,
	input  wire [1:0]            rev_store_clk,
	// test port
	input  wire                  tck,
	input  wire                  tms,
	input  wire                  tdi,
	output reg                   tdo,
	output reg                   tdo_oe
);

localparam DW = 2 * HALF_W;
localparam P  = 2 * DW;
localparam SW = P + 15;

// sampler reset image: output enables off, tms and tdi at pull-up level,
// so no bus is driven and no false edge is seen while pins settle
localparam [SW-1:0] IN_IDLE = {3'b110, 4'h0, 4'h0, 4'hf, {P{1'b0}}};

localparam [1:0] SEL_BYP = 2'h0;
localparam [1:0] SEL_BSR = 2'h1;
localparam [1:0] SEL_BCR = 2'h2;
localparam [1:0] SEL_ID  = 2'h3;

// ****************************************************
// functions
// ****************************************************

// one enable bit per half, widened to the data lanes
function [DW-1:0] spread;
	input [1:0] en;
	begin
		spread = {{HALF_W{en[1]}}, {HALF_W{en[0]}}};
	end
endfunction

// one step of the pattern shifter over the data cells
function [P-1:0] lfsr_step;
	input [P-1:0] v;
	begin
		lfsr_step = {v[P-2:0], v[P-1] ^ v[P-12]};
	end
endfunction

// ****************************************************
// input sampling
// ****************************************************
wire [SW-1:0] raw;
reg  [SW-1:0] in_meta;
reg  [SW-1:0] in_s;

assign raw = {tdi, tms, tck, rev_store_clk, fwd_store_clk,
	rev_latch_en, fwd_latch_en, rev_out_en_n, fwd_out_en_n,
	b_in, a_in};

// every pin crosses two flops before use
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		in_meta <= IN_IDLE;
		in_s <= IN_IDLE;
	end else begin
		in_meta <= raw;
		in_s <= in_meta;
	end
end

wire [DW-1:0] a_s    = in_s[DW-1:0];
wire [DW-1:0] b_s    = in_s[P-1:DW];
wire [1:0]    f_oen  = in_s[P+1:P];
wire [1:0]    r_oen  = in_s[P+3:P+2];
wire [1:0]    f_le   = in_s[P+5:P+4];
wire [1:0]    r_le   = in_s[P+7:P+6];
wire [1:0]    f_ck   = in_s[P+9:P+8];
wire [1:0]    r_ck   = in_s[P+11:P+10];
wire          tck_s  = in_s[P+12];
wire          tms_s  = in_s[P+13];
wire          tdi_s  = in_s[P+14];

// boundary capture image: enables, latches, clocks, A, B
wire [`BSR_W-1:0] cap_vec = {r_oen, f_oen, r_le, f_le,
	r_ck, f_ck, a_s, b_s};

// ****************************************************
// normal-mode data paths
// ****************************************************
wire [DW-1:0] fwd_q;
wire [DW-1:0] rev_q;

// each half has its own enables; tie them for 18-bit use
genvar h;
generate
	for (h = 0; h < 2; h = h + 1) begin : half
		store_path #(
			.W (HALF_W)
		) u_fwd (
			.sys_clk   (sys_clk),
			.nrst      (nrst),
			.d         (a_s[h*HALF_W +: HALF_W]),
			.latch_en  (f_le[h]),
			.store_clk (f_ck[h]),
			.q         (fwd_q[h*HALF_W +: HALF_W])
		);
		store_path #(
			.W (HALF_W)
		) u_rev (
			.sys_clk   (sys_clk),
			.nrst      (nrst),
			.d         (b_s[h*HALF_W +: HALF_W]),
			.latch_en  (r_le[h]),
			.store_clk (r_ck[h]),
			.q         (rev_q[h*HALF_W +: HALF_W])
		);
	end
endgenerate

// ****************************************************
// test port sequencing
// ****************************************************
reg        tck_d;
wire       tck_rise = tck_s & ~tck_d;
wire       tck_fall = ~tck_s & tck_d;
wire [3:0] state;

// only test clock and mode select drive the controller
tap_states u_tap (
	.sys_clk  (sys_clk),
	.nrst     (nrst),
	.tck_rise (tck_rise),
	.tms      (tms_s),
	.state    (state)
);

// ****************************************************
// test registers
// ****************************************************
reg [`IR_W-1:0]  ir_sh;
reg [`IR_W-1:0]  ir_upd;
reg [`BSR_W-1:0] bsr_sh;
reg [`BSR_W-1:0] upd;
reg [`BCR_W-1:0] bcr_sh;
reg [`BCR_W-1:0] bcr_upd;
reg              byp;
reg [`ID_W-1:0]  id_sh;
reg [P-1:0]      pin_snap;

reg [1:0] sel;
reg       test_mode;
reg       highz;
reg       tdo_next;

// instruction decode; unknown opcodes fall back to bypass
always @* begin
	sel = SEL_BYP;
	test_mode = 1'b0;
	highz = 1'b0;
	case (ir_upd)
	`OP_EXTEST: begin
		sel = SEL_BSR;
		test_mode = 1'b1;
	end
	`OP_INTEST: begin
		sel = SEL_BSR;
		test_mode = 1'b1;
	end
	`OP_SAMPLE: sel = SEL_BSR;
	`OP_IDCODE: sel = SEL_ID;
	`OP_SCANCN: sel = SEL_BCR;
	`OP_HIGHZ: begin
		test_mode = 1'b1;
		highz = 1'b1;
	end
	`OP_CLAMP: test_mode = 1'b1;
	`OP_RUNT: test_mode = 1'b1;
	default: sel = SEL_BYP;
	endcase
end

// serial output source for the scan in progress
always @* begin
	case (sel)
	SEL_BSR: tdo_next = bsr_sh[0];
	SEL_BCR: tdo_next = bcr_sh[0];
	SEL_ID:  tdo_next = id_sh[0];
	default: tdo_next = byp;
	endcase
	if (state == `TAP_SHIR)
		tdo_next = ir_sh[0];
end

// capture and shift on the rise, update and drive on the fall
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		tck_d <= 1'b0;
		ir_sh <= `IR_RESET;
		ir_upd <= `IR_RESET;
		bsr_sh <= {`BSR_W{1'b0}};
		upd <= {`BSR_OE_SET, {(`BSR_W-4){1'b0}}};
		bcr_sh <= `BCR_RESET;
		bcr_upd <= `BCR_RESET;
		byp <= 1'b0;
		id_sh <= ID_CODE;
		pin_snap <= {P{1'b0}};
		tdo <= 1'b0;
		tdo_oe <= 1'b0;
	end else begin
		tck_d <= tck_s;
		if (tck_rise) begin
			pin_snap <= {a_s, b_s};
			case (state)
			`TAP_CIR: ir_sh <= `IR_CAPTURE;
			`TAP_SHIR: ir_sh <= {tdi_s, ir_sh[`IR_W-1:1]};
			`TAP_CDR: begin
				// pin snapshot without touching the data flow
				if (sel == SEL_BSR)
					bsr_sh <= cap_vec;
				if (sel == SEL_BCR)
					bcr_sh <= bcr_upd;
				if (sel == SEL_ID)
					id_sh <= ID_CODE;
				if (sel == SEL_BYP)
					byp <= 1'b0;
			end
			`TAP_SHDR: begin
				case (sel)
				SEL_BSR:
					bsr_sh <= {tdi_s, bsr_sh[`BSR_W-1:1]};
				SEL_BCR:
					bcr_sh <= {tdi_s, bcr_sh[`BCR_W-1:1]};
				SEL_ID:
					id_sh <= {tdi_s, id_sh[`ID_W-1:1]};
				default: byp <= tdi_s;
				endcase
			end
			default: ;
			endcase
		end
		if (tck_fall) begin
			tdo <= tdo_next;
			tdo_oe <= (state == `TAP_SHIR) ||
				(state == `TAP_SHDR);
			if (state == `TAP_UIR)
				ir_upd <= ir_sh;
			if (state == `TAP_UDR && sel == SEL_BSR)
				upd <= bsr_sh;
			if (state == `TAP_UDR && sel == SEL_BCR)
				bcr_upd <= bcr_sh;
			// run-test operations act on the data cells only
			if (state == `TAP_RTI && ir_upd == `OP_RUNT) begin
				case (bcr_upd)
				`BCR_PSA: upd[P-1:0] <=
					lfsr_step(upd[P-1:0]) ^ pin_snap;
				`BCR_OUTPUT_RANDOM_PATTERN: upd[P-1:0] <=
					lfsr_step(upd[P-1:0]);
				`BCR_COUNT: upd[P-1:0] <=
					upd[P-1:0] + {{(P-1){1'b0}}, 1'b1};
				`BCR_TOGGLE: begin
					upd[P-1:0] <= ~upd[P-1:0];
					bsr_sh[P-1:0] <= pin_snap;
				end
				default: ;
				endcase
			end
		end
		// held in reset state: outputs safe if test mode follows
		if (state == `TAP_TLR) begin
			ir_upd <= `IR_RESET;
			bcr_upd <= `BCR_RESET;
			upd[`BSR_W-1:`BSR_OE_LO] <= `BSR_OE_SET;
		end
	end
end

// ****************************************************
// pin drivers
// ****************************************************

// test mode owns the pins; otherwise the transceiver drives them
always @(posedge sys_clk or negedge nrst) begin
	if (!nrst) begin
		a_out <= {DW{1'b0}};
		a_oe <= {DW{1'b0}};
		b_out <= {DW{1'b0}};
		b_oe <= {DW{1'b0}};
	end else if (test_mode) begin
		a_out <= upd[`BSR_A_LO +: DW];
		b_out <= upd[`BSR_B_LO +: DW];
		a_oe <= highz ? {DW{1'b0}} :
			spread(~upd[`BSR_W-1:`BSR_W-2]);
		b_oe <= highz ? {DW{1'b0}} :
			spread(~upd[`BSR_OE_LO+1:`BSR_OE_LO]);
	end else begin
		b_out <= fwd_q;
		b_oe <= spread(~f_oen);
		a_out <= rev_q;
		a_oe <= spread(~r_oen);
	end
end

endmodule

// ===== testbench/scan_checker.sv
/* pin checker of the scan transceiver.
 * assumes the top module's ports, bound at the foot. */
module scan_checker (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        nrst,
	// pins
	input wire logic [17:0] a_in,
	input wire logic [17:0] a_oe,
	input wire logic [17:0] b_out,
	input wire logic [17:0] b_oe,
	// controls
	input wire logic [1:0]  fwd_out_en_n,
	input wire logic [1:0]  rev_out_en_n,
	input wire logic [1:0]  fwd_latch_en,
	input wire logic [1:0]  fwd_store_clk,
	// test port
	input wire logic        tck,
	input wire logic        tms,
	input wire logic        tdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic [1:0] tk;
	logic [2:0] hi;
	logic [3:0] nc;
	logic       ok;
	// normal mode only after five high tms rises; drops early, never late
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			tk <= 2'h0;
			hi <= 3'h5;
			nc <= 4'hf;
		end else begin
			tk <= {tk[0], tck};
			if (tk == 2'h1)
				hi <= tms ? ((hi == 3'h5) ? hi : hi + 3'h1) : 3'h0;
			nc <= (hi != 3'h5) ? 4'h0 : ((nc == 4'hf) ? nc : nc + 4'h1);
		end
	end
	assign ok = (nc == 4'hf);

	property p_b_drive;
		(ok && !fwd_out_en_n[0]) [*6] |-> b_oe[8:0] == 9'h1ff;
	endproperty
	a_b_drive: assert property (p_b_drive)
		else $error("b half one not driven");
	property p_b_float;
		(ok && fwd_out_en_n[1]) [*6] |-> b_oe[17:9] == 9'h0;
	endproperty
	a_b_float: assert property (p_b_float)
		else $error("b half two not floated");
	property p_a_drive;
		(ok && !rev_out_en_n[0]) [*6] |-> a_oe[8:0] == 9'h1ff;
	endproperty
	a_a_drive: assert property (p_a_drive)
		else $error("a half one not driven");
	property p_a_float;
		(ok && rev_out_en_n[1]) [*6] |-> a_oe[17:9] == 9'h0;
	endproperty
	a_a_float: assert property (p_a_float)
		else $error("a half two not floated");
	property p_transp;
		(ok && fwd_latch_en[0] && !fwd_out_en_n[0] && $stable(a_in[8:0]))
			[*6] |-> b_out[8:0] == a_in[8:0];
	endproperty
	a_transp: assert property (p_transp)
		else $error("open latch does not pass data");
	property p_hold;
		(ok && !fwd_latch_en[0] && !fwd_store_clk[0] && !fwd_out_en_n[0])
			[*6] |=> $stable(b_out[8:0]);
	endproperty
	a_hold: assert property (p_hold)
		else $error("closed latch output moved");
	property p_store;
		ok && !fwd_latch_en[0] && !fwd_out_en_n[0] && $rose(fwd_store_clk[0])
			|-> ##6 b_out[8:0] == $past(a_in[8:0], 6);
	endproperty
	a_store: assert property (p_store)
		else $error("store clock rise not stored");
	property p_tdo_edge;
		$changed(tdo_oe) |-> $past(tck, 2) == 1'b0;
	endproperty
	a_tdo_edge: assert property (p_tdo_edge)
		else $error("test output moved in high phase");
	property p_quiet;
		ok |-> !tdo_oe;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("test output driven in reset state");
endmodule

bind scan_bus_transceiver_18bit scan_checker i_scan_checker (
	.sys_clk, .nrst, .a_in, .a_oe, .b_out, .b_oe, .fwd_out_en_n,
	.rev_out_en_n, .fwd_latch_en, .fwd_store_clk, .tck, .tms, .tdo_oe
);

// ===== testbench/bus_partner.sv
/* far side: two buses with far drivers and a test controller.
 * assumes the bench calls to_rti and scan from its main sequence. */
module bus_partner (
	// device pins
	input  wire logic [17:0] a_out,
	input  wire logic [17:0] a_oe,
	input  wire logic [17:0] b_out,
	input  wire logic [17:0] b_oe,
	output logic      [17:0] a_in,
	output logic      [17:0] b_in,
	// levels of the other bus drivers
	input  wire logic [17:0] a_drv,
	input  wire logic [17:0] b_drv,
	// test port, pull-ups keep tms and tdi high
	output logic             tck,
	output logic             tms,
	output logic             tdi,
	input  wire logic        tdo,
	input  wire logic        tdo_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic tdo_line;
	// device wins where it drives, else the far driver
	assign a_in = (a_oe & a_out) | (~a_oe & a_drv);
	assign b_in = (b_oe & b_out) | (~b_oe & b_drv);
	// released tdo has no pull: show the inverse so a late enable shows
	assign tdo_line = tdo_oe ? tdo : ~tdo;
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// one test clock, 64 ns, sampling tdo late in the low phase
	task step(input logic t, input logic d, output logic o);
		tms <= t;
		tdi <= d;
		#32;
		o = tdo_line;
		tck <= 1'b1;
		#32;
		tck <= 1'b0;
	endtask
	task to_rti();
		logic o;
		repeat (5) step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask
	// from idle, scan n bits lsb first, back to idle
	task scan(input logic ir, input int n, input logic [47:0] din,
	          output logic [47:0] dout);
		logic o;
		dout = 48'h0;
		step(1'b1, 1'b1, o);
		if (ir)
			step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
		step(1'b0, 1'b1, o);
		for (int i = 0; i < n; i++)
			step(i == n - 1, din[i], dout[i]);
		step(1'b1, 1'b1, o);
		step(1'b0, 1'b1, o);
	endtask
endmodule

// ===== testbench/tb_top.sv
/* self-checking bench of the scan transceiver.
 * assumes bus_partner for the far side and the bound checker. */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam [31:0] ID = 32'h0a5a_0001; // arbitrary value
	logic        sys_clk, nrst, tck, tms, tdi, tdo, tdo_oe;
	logic [17:0] a_in, a_out, a_oe, b_in, b_out, b_oe, a_drv, b_drv;
	logic [1:0]  fo, ro, fl, rl, fc, rc;
	logic [47:0] d, q;
	logic [35:0] cnt_val;
	logic        o;
	int          n_mismatch, comparisons, i, n;

	scan_bus_transceiver_18bit #(.HALF_W(9), .ID_CODE(ID))
	i_scan_bus_transceiver_18bit (
		.sys_clk(sys_clk), .nrst(nrst), .a_in(a_in), .a_out(a_out),
		.a_oe(a_oe), .b_in(b_in), .b_out(b_out), .b_oe(b_oe),
		.fwd_out_en_n(fo), .rev_out_en_n(ro), .fwd_latch_en(fl),
		.rev_latch_en(rl), .fwd_store_clk(fc), .rev_store_clk(rc),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));
	bus_partner i_bus_partner (
		.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
		.a_in(a_in), .b_in(b_in), .a_drv(a_drv), .b_drv(b_drv),
		.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

	// clock
	initial sys_clk = 1'b0;
	always #4 sys_clk = ~sys_clk;

	task chk(input logic [47:0] s, input logic [47:0] e);
		comparisons++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// enabled bits of a port from its active-low half enables
	function logic [17:0] oem(input logic [1:0] en_n);
		return {{9{~en_n[1]}}, {9{~en_n[0]}}};
	endfunction
	// boundary capture image from the control pins and both bus levels
	function logic [47:0] cap(input logic [17:0] av, input logic [17:0] bv);
		return {ro, fo, rl, fl, rc, fc, av, bv};
	endfunction
	// one pattern step over the 36 data cells, feedback 35 xor 24
	function logic [35:0] output_random_pattern(input logic [35:0] v);
		return {v[34:0], v[35] ^ v[24]};
	endfunction
	task results();
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// watchdog, well past the roughly 24 us of scans
	initial begin
		#400000;
		n_mismatch++;
		results();
	end

	initial begin
		{nrst, a_drv, b_drv, fc, rc} = '0;
		{fo, ro, fl, rl} = 8'hff;
		i = $urandom(32'h3667220a);
		cyc(3);
		nrst <= 1'b1;
		cyc(2);
		// all four forward enable settings, reverse enables inverted, random data
		for (i = 0; i < 4; i++) begin
			fo <= i[1:0];
			ro <= ~i[1:0];
			a_drv <= 18'($urandom);
			b_drv <= 18'($urandom);
			cyc(8);
			chk(b_oe, oem(fo));
			chk(a_oe, oem(ro));
			chk(b_out & oem(fo), a_drv & oem(fo));
			chk(a_out & oem(ro), b_drv & oem(ro));
		end
		// closed latch, store on rise only, then half one alone
		fo <= 2'h0;
		ro <= 2'h3;
		fl <= 2'h0;
		cyc(8);
		fc <= 2'h3;
		cyc(8);
		d = a_drv;
		chk(b_out, d);
		a_drv <= 18'($urandom);
		cyc(8);
		chk(b_out, d);
		fc <= 2'h0;
		cyc(8);
		chk(b_out, d);
		fc <= 2'h1;
		cyc(8);
		chk(b_out, {d[17:9], a_drv[8:0]});
		fl <= 2'h3;
		// scans in normal mode
		i_bus_partner.to_rti();
		i_bus_partner.scan(1'b0, 32, 48'h0, q);
		chk(q[31:0], ID);
		i_bus_partner.scan(1'b1, 8, 48'hff, q);
		chk(q[7:0], 8'h81);
		d = $urandom;
		i_bus_partner.scan(1'b0, 8, d, q);
		chk(q[7:0], {d[6:0], 1'b0});
		chk(b_out, a_drv);
		i_bus_partner.to_rti();
		i_bus_partner.scan(1'b0, 32, 48'h0, q);
		chk(q[31:0], ID);
		i_bus_partner.scan(1'b1, 8, 48'h82, q);
		i_bus_partner.scan(1'b0, 48, 48'h0, q);
		// B is driven from A through the open latch
		chk(q, cap(a_drv, a_drv));
		chk(b_oe, oem(fo));
		// test mode: safe enables after reset, then driven pins
		i_bus_partner.to_rti();
		i_bus_partner.scan(1'b1, 8, 48'h0, q);
		cyc(4);
		chk({a_oe, b_oe}, 36'h0);
		d = {12'h0, 18'($urandom), 18'($urandom)};
		i_bus_partner.scan(1'b0, 48, d, q);
		chk(q, cap(a_drv, b_drv));
		cyc(4);
		chk({a_out, b_out}, d[35:0]);
		chk({a_oe, b_oe}, {36{1'b1}});
		// floating, then clamped to the update stages
		for (i = 0; i < 2; i++) begin
			i_bus_partner.scan(1'b1, 8, i ? 48'h87 : 48'h06, q);
			cyc(4);
			chk({a_oe, b_oe}, i ? {36{1'b1}} : 36'h0);
		end
		// control register: reset op read back, then count in idle
		i_bus_partner.scan(1'b1, 8, 48'h0a, q);
		i_bus_partner.scan(1'b0, 3, 48'h3, q);
		chk(q[2:0], 3'h2);
		i_bus_partner.scan(1'b1, 8, 48'h09, q);
		n = $urandom_range(8, 1);
		repeat (n) i_bus_partner.step(1'b0, 1'b1, o);
		cyc(6);
		// one count on the idle fall closing the scan, then n more
		cnt_val = d[35:0] + 36'(n + 1);
		chk({a_out, b_out}, cnt_val);
		// pattern generation: one step on the closing idle fall
		i_bus_partner.scan(1'b1, 8, 48'h0a, q);
		i_bus_partner.scan(1'b0, 3, 48'h1, q);
		chk(q[2:0], 3'h3);
		i_bus_partner.scan(1'b1, 8, 48'h09, q);
		cyc(6);
		chk({a_out, b_out}, output_random_pattern(cnt_val));
		results();
	end
endmodule
